// file: verilog/apc_pkg.sv
// Shared constants, register map and types for the converter power and control-mode block
`default_nettype none

package apc_pkg;

    // Clock period of the sample-clock domain
    localparam int CLK_PERIOD_NS = 8;

    // Power-on calibration delays and calibration length, in their own unit
    localparam int POR_SHORT_DELAY_NS = 8192;
    localparam int POR_LONG_DELAY_NS = 65536;
    localparam int CAL_TIME_NS = 16384;

    // Least times, rounded up to whole cycles
    localparam int POR_SHORT_CYCLES = (POR_SHORT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_LONG_CYCLES = (POR_LONG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Serial frame layout: 12-bit header, 4-bit address, 16-bit data, MSB first
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int FRAME_W = 32;
    localparam logic [4:0] FRAME_LAST = 5'h1f;
    localparam logic [11:0] FRAME_HEADER = 12'h001;
    localparam int HDR_MSB = 31;
    localparam int HDR_LSB = 20;
    localparam int ADDR_MSB = 19;
    localparam int ADDR_LSB = 16;

    // Register addresses
    localparam logic [3:0] REG_CONFIG = 4'h1;
    localparam logic [3:0] REG_OFFSET = 4'h2;
    localparam logic [3:0] REG_RANGE = 4'h3;
    localparam logic [3:0] REG_DUAL_EDGE = 4'hd;
    localparam logic [3:0] REG_COARSE = 4'he;
    localparam logic [3:0] REG_FINE = 4'hf;

    // Reset values
    localparam logic [15:0] CONFIG_RESET = 16'hb2ff;
    localparam logic [15:0] OFFSET_RESET = 16'h0000;
    localparam logic [15:0] RANGE_RESET = 16'h8000;
    localparam logic [15:0] DUAL_EDGE_RESET = 16'h0000;
    localparam logic [15:0] PHASE_RESET = 16'h0000;

    // Configuration register fields
    localparam int CFG_PHASE_BIT = 11;
    localparam int CFG_SDR_BIT = 10;
    localparam int CFG_AMP_BIT = 9;
    localparam int CFG_OE_BIT = 8;

    // Adjust fields, offset and full-scale range
    localparam int ADJ_MSB = 15;
    localparam int ADJ_LSB = 7;
    localparam int ADJ_W = 9;
    localparam logic [8:0] ADJ_NONE = 9'h000;

    // Dual-edge enable register fields
    localparam int DE_ENABLE_BIT = 15;
    localparam int DE_AUTO_BIT = 14;
    localparam int DE_QSEL_BIT = 13;

    // Power and calibration sequencer states
    typedef enum logic [2:0] {
        ST_POR_HOLD,
        ST_POR_DELAY,
        ST_CAL,
        ST_ACTIVE,
        ST_PWRDN
    } apc_cal_state_t;

endpackage : apc_pkg

`default_nettype wire

// file: verilog/apc_serial_rx.sv
// Three-wire serial write port: frame capture and header check
`timescale 1ns/10ps
`default_nettype none

module apc_serial_rx (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Port enable, extended mode only
    input wire logic i_enable,
    // Serial pins, sampled on i_mclk
    input wire logic i_sclk,
    input wire logic i_sdata,
    input wire logic i_scs_n,
    // Decoded write
    output logic o_we,
    output logic [apc_pkg::ADDR_W-1:0] o_addr,
    output logic [apc_pkg::DATA_W-1:0] o_data
);

    logic sclk_d;
    logic [4:0] bit_cnt;
    logic [apc_pkg::FRAME_W-1:0] shift;

    // Rising serial clock while selected; frame closes on the 32nd bit
    wire sclk_rise = i_enable & ~i_scs_n & i_sclk & ~sclk_d;
    wire [apc_pkg::FRAME_W-1:0] frame = {shift[apc_pkg::FRAME_W-2:0], i_sdata};
    wire frame_done = sclk_rise && (bit_cnt == apc_pkg::FRAME_LAST);
    wire header_ok = frame[apc_pkg::HDR_MSB:apc_pkg::HDR_LSB] == apc_pkg::FRAME_HEADER;

    // Counter wraps, so frames may follow back to back without deselect
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sclk_d <= 1'b0;
            bit_cnt <= 5'h00;
            shift <= '0;
            o_we <= 1'b0;
            o_addr <= '0;
            o_data <= '0;
        end else begin
            sclk_d <= i_sclk;
            o_we <= frame_done & header_ok;
            if (!i_enable || i_scs_n) begin
                bit_cnt <= 5'h00;
            end else if (sclk_rise) begin
                shift <= frame;
                bit_cnt <= bit_cnt + 5'h01;
            end
            if (frame_done) begin
                o_addr <= frame[apc_pkg::ADDR_MSB:apc_pkg::ADDR_LSB];
                o_data <= frame[apc_pkg::DATA_W-1:0];
            end
        end
    end

endmodule : apc_serial_rx

`default_nettype wire

// file: verilog/apc_cal_seq.sv
// Power-down and calibration sequencer
`timescale 1ns/10ps
`default_nettype none

module apc_cal_seq #(
    parameter int SHORT_CYCLES = apc_pkg::POR_SHORT_CYCLES,
    parameter int LONG_CYCLES = apc_pkg::POR_LONG_CYCLES,
    parameter int CAL_CYCLES = apc_pkg::CAL_CYCLES,
    parameter int CNT_W = 20
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Control levels
    input wire logic i_power_down_request,
    input wire logic i_q_channel_sleep,
    input wire logic i_long_delay,
    input wire logic i_cal_request,
    // State view
    output logic o_powered_down,
    output logic o_cal_busy,
    output logic o_cal_q,
    output logic o_active,
    output logic o_por_hold
);

    apc_pkg::apc_cal_state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic cal_q, next_cal_q;
    logic cal_req_d;

    // Load value for a down-counter ending at zero
    function automatic logic [CNT_W-1:0] load_of(input int n);
        load_of = CNT_W'(n - 1);
    endfunction : load_of

    // Manual calibration acts on its rising edge only
    wire cal_edge = i_cal_request & ~cal_req_d;
    wire sleep_req = i_power_down_request;

    // Next-state logic
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_cal_q = cal_q;
        unique case (state)
            apc_pkg::ST_POR_HOLD: begin
                if (!sleep_req) begin
                    next_state = apc_pkg::ST_POR_DELAY;
                    next_cnt = i_long_delay ? load_of(LONG_CYCLES) : load_of(SHORT_CYCLES);
                end
            end
            apc_pkg::ST_POR_DELAY: begin
                if (sleep_req) begin
                    next_state = apc_pkg::ST_POR_HOLD;
                end else if (cnt == '0) begin
                    next_state = apc_pkg::ST_CAL;
                    next_cnt = load_of(CAL_CYCLES);
                    next_cal_q = ~i_q_channel_sleep;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            apc_pkg::ST_CAL: begin
                // Power-down waits for the sequence to finish
                if (cnt == '0) begin
                    next_state = sleep_req ? apc_pkg::ST_PWRDN : apc_pkg::ST_ACTIVE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            apc_pkg::ST_ACTIVE: begin
                if (sleep_req) begin
                    next_state = apc_pkg::ST_PWRDN;
                end else if (cal_edge) begin
                    next_state = apc_pkg::ST_CAL;
                    next_cnt = load_of(CAL_CYCLES);
                    next_cal_q = ~i_q_channel_sleep;
                end
            end
            apc_pkg::ST_PWRDN: begin
                // Requests seen here are dropped, not deferred
                if (!sleep_req) begin
                    next_state = apc_pkg::ST_ACTIVE;
                end
            end
            default: next_state = apc_pkg::ST_POR_HOLD;
        endcase
    end

    // State registers
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state <= apc_pkg::ST_POR_HOLD;
            cnt <= '0;
            cal_q <= 1'b0;
            cal_req_d <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            cal_q <= next_cal_q;
            cal_req_d <= i_cal_request;
        end
    end

    // State decode
    assign o_powered_down = (state == apc_pkg::ST_PWRDN) || (state == apc_pkg::ST_POR_HOLD);
    assign o_cal_busy = state == apc_pkg::ST_CAL;
    assign o_cal_q = cal_q;
    assign o_active = state == apc_pkg::ST_ACTIVE;
    assign o_por_hold = state == apc_pkg::ST_POR_HOLD;

endmodule : apc_cal_seq

`default_nettype wire

// file: verilog/apc_top.sv
// Converter power-down, calibration gating and normal/extended control selection
`timescale 1ns/10ps
`default_nettype none

module apc_top #(
    parameter int POR_SHORT_CYCLES = apc_pkg::POR_SHORT_CYCLES,
    parameter int POR_LONG_CYCLES = apc_pkg::POR_LONG_CYCLES,
    parameter int CAL_CYCLES = apc_pkg::CAL_CYCLES
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Power and calibration pins
    input wire logic i_power_down_request,
    input wire logic i_q_channel_sleep,
    input wire logic i_cal_request,
    // Feature pins, normal mode
    input wire logic i_extended_control_enable,
    input wire logic i_full_scale_select,
    input wire logic i_output_edge_pin,
    input wire logic i_output_edge_float,
    input wire logic i_amplitude_pin,
    input wire logic i_calibration_delay_select,
    // Serial register port
    input wire logic i_sclk,
    input wire logic i_sdata,
    input wire logic i_scs_n,
    // Power controls
    output logic o_data_out_en,
    output logic o_weak_pulldown,
    output logic o_i_channel_on,
    output logic o_q_channel_on,
    output logic o_cal_busy,
    output logic o_cal_q_channel,
    // Output format controls
    output logic o_ddr_mode,
    output logic o_ddr_clock_phase,
    output logic o_rising_edge_out,
    output logic o_lvds_amplitude_select,
    // Analog trims
    output logic o_extended_mode,
    output logic o_full_scale_select,
    output logic [apc_pkg::ADJ_W-1:0] o_range_adjust,
    output logic [apc_pkg::ADJ_W-1:0] o_offset_adjust,
    // Dual-edge sampling
    output logic o_dual_edge_enable,
    output logic o_dual_edge_q_input,
    output logic o_dual_edge_auto_phase,
    output logic [apc_pkg::DATA_W-1:0] o_phase_coarse,
    output logic [apc_pkg::DATA_W-1:0] o_phase_fine
);

    // Mode strap and register file
    logic strap_done;
    logic extended_control_enable;
    logic [15:0] configuration_control;
    logic [15:0] i_channel_offset_adjust;
    logic [15:0] i_channel_range_adjust;
    logic [15:0] dual_edge_enable;
    logic [15:0] dual_edge_phase_coarse;
    logic [15:0] dual_edge_phase_fine;

    // Serial receiver and sequencer wires
    logic rx_we;
    logic [apc_pkg::ADDR_W-1:0] rx_addr;
    logic [apc_pkg::DATA_W-1:0] rx_data;
    logic seq_powered_down;
    logic seq_cal_busy;
    logic seq_cal_q;
    logic seq_active;
    logic seq_por_hold;

    // Mode is caught once after reset and never retaken
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            strap_done <= 1'b0;
            extended_control_enable <= 1'b0;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            extended_control_enable <= i_extended_control_enable;
        end
    end

    // Sequencer held until the mode is known, so the delay choice is valid
    wire seq_rst = i_rst | ~strap_done;
    wire ext = extended_control_enable;

    // Port is dead in normal mode
    apc_serial_rx u_rx (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_enable(ext & strap_done),
        .i_sclk(i_sclk),
        .i_sdata(i_sdata),
        .i_scs_n(i_scs_n),
        .o_we(rx_we),
        .o_addr(rx_addr),
        .o_data(rx_data)
    );

    // Long delay only reachable from the pin in normal mode
    wire long_delay = ~ext & i_calibration_delay_select;

    apc_cal_seq #(
        .SHORT_CYCLES(POR_SHORT_CYCLES),
        .LONG_CYCLES(POR_LONG_CYCLES),
        .CAL_CYCLES(CAL_CYCLES)
    ) u_seq (
        .i_mclk(i_mclk),
        .i_rst(seq_rst),
        .i_power_down_request(i_power_down_request),
        .i_q_channel_sleep(i_q_channel_sleep),
        .i_long_delay(long_delay),
        .i_cal_request(i_cal_request),
        .o_powered_down(seq_powered_down),
        .o_cal_busy(seq_cal_busy),
        .o_cal_q(seq_cal_q),
        .o_active(seq_active),
        .o_por_hold(seq_por_hold)
    );

    // Write decode; unlisted addresses are dropped
    wire wr_cfg = rx_we && (rx_addr == apc_pkg::REG_CONFIG);
    wire wr_offset = rx_we && (rx_addr == apc_pkg::REG_OFFSET);
    wire wr_range = rx_we && (rx_addr == apc_pkg::REG_RANGE);
    wire wr_dual = rx_we && (rx_addr == apc_pkg::REG_DUAL_EDGE);
    wire wr_coarse = rx_we && (rx_addr == apc_pkg::REG_COARSE);
    wire wr_fine = rx_we && (rx_addr == apc_pkg::REG_FINE);

    // Write-only registers, extended-mode defaults at reset
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            configuration_control <= apc_pkg::CONFIG_RESET;
            i_channel_offset_adjust <= apc_pkg::OFFSET_RESET;
            i_channel_range_adjust <= apc_pkg::RANGE_RESET;
            dual_edge_enable <= apc_pkg::DUAL_EDGE_RESET;
            dual_edge_phase_coarse <= apc_pkg::PHASE_RESET;
            dual_edge_phase_fine <= apc_pkg::PHASE_RESET;
        end else begin
            if (wr_cfg) configuration_control <= rx_data;
            if (wr_offset) i_channel_offset_adjust <= rx_data;
            if (wr_range) i_channel_range_adjust <= rx_data;
            if (wr_dual) dual_edge_enable <= rx_data;
            if (wr_coarse) dual_edge_phase_coarse <= rx_data;
            if (wr_fine) dual_edge_phase_fine <= rx_data;
        end
    end

    // Power state mapping; I cannot sleep on its own
    wire next_data_out_en = ~seq_powered_down;
    wire next_weak_pulldown = seq_powered_down;
    wire next_q_on = ~seq_powered_down & ~i_q_channel_sleep;
    wire next_cal_q_channel = seq_cal_busy & seq_cal_q & ~i_q_channel_sleep;

    // Format selection: pins in normal mode (DDR phase held low), register bits in extended
    wire next_ddr = ext ? ~configuration_control[apc_pkg::CFG_SDR_BIT]
                        : i_output_edge_float;
    wire next_phase = ext & configuration_control[apc_pkg::CFG_PHASE_BIT];
    wire next_rising = ext ? configuration_control[apc_pkg::CFG_OE_BIT]
                           : i_output_edge_pin;
    wire next_amp = ext ? configuration_control[apc_pkg::CFG_AMP_BIT]
                        : i_amplitude_pin;

    // Trims: pin range in normal mode, adjust fields in extended
    wire next_fs_sel = ~ext & i_full_scale_select;
    wire [apc_pkg::ADJ_W-1:0] next_range = ext
        ? i_channel_range_adjust[apc_pkg::ADJ_MSB:apc_pkg::ADJ_LSB]
        : apc_pkg::RANGE_RESET[apc_pkg::ADJ_MSB:apc_pkg::ADJ_LSB];
    wire [apc_pkg::ADJ_W-1:0] next_offset = ext
        ? i_channel_offset_adjust[apc_pkg::ADJ_MSB:apc_pkg::ADJ_LSB]
        : apc_pkg::ADJ_NONE;

    // Dual-edge: pin shares the delay-select input in normal mode
    wire next_de_en = ext ? dual_edge_enable[apc_pkg::DE_ENABLE_BIT]
                          : i_calibration_delay_select;
    wire next_de_q = ext & dual_edge_enable[apc_pkg::DE_QSEL_BIT];
    wire next_de_auto = ~ext | dual_edge_enable[apc_pkg::DE_AUTO_BIT];
    wire [apc_pkg::DATA_W-1:0] next_coarse = ext ? dual_edge_phase_coarse : apc_pkg::PHASE_RESET;
    wire [apc_pkg::DATA_W-1:0] next_fine = ext ? dual_edge_phase_fine : apc_pkg::PHASE_RESET;

    // Output flops; reset state is powered down with data tri-stated
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_data_out_en <= 1'b0;
            o_weak_pulldown <= 1'b1;
            o_i_channel_on <= 1'b0;
            o_q_channel_on <= 1'b0;
            o_cal_busy <= 1'b0;
            o_cal_q_channel <= 1'b0;
            o_ddr_mode <= 1'b0;
            o_ddr_clock_phase <= 1'b0;
            o_rising_edge_out <= 1'b0;
            o_lvds_amplitude_select <= 1'b0;
            o_extended_mode <= 1'b0;
            o_full_scale_select <= 1'b0;
            o_range_adjust <= apc_pkg::ADJ_NONE;
            o_offset_adjust <= apc_pkg::ADJ_NONE;
            o_dual_edge_enable <= 1'b0;
            o_dual_edge_q_input <= 1'b0;
            o_dual_edge_auto_phase <= 1'b0;
            o_phase_coarse <= apc_pkg::PHASE_RESET;
            o_phase_fine <= apc_pkg::PHASE_RESET;
        end else begin
            o_data_out_en <= next_data_out_en;
            o_weak_pulldown <= next_weak_pulldown;
            o_i_channel_on <= next_data_out_en;
            o_q_channel_on <= next_q_on;
            o_cal_busy <= seq_cal_busy;
            o_cal_q_channel <= next_cal_q_channel;
            o_ddr_mode <= next_ddr;
            o_ddr_clock_phase <= next_phase;
            o_rising_edge_out <= next_rising;
            o_lvds_amplitude_select <= next_amp;
            o_extended_mode <= ext;
            o_full_scale_select <= next_fs_sel;
            o_range_adjust <= next_range;
            o_offset_adjust <= next_offset;
            o_dual_edge_enable <= next_de_en;
            o_dual_edge_q_input <= next_de_q;
            o_dual_edge_auto_phase <= next_de_auto;
            o_phase_coarse <= next_coarse;
            o_phase_fine <= next_fine;
        end
    end

    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    sequence s_sleep_from_active;
        seq_active && i_power_down_request;
    endsequence

    sequence s_cal_req_while_asleep;
        seq_powered_down && strap_done && !seq_por_hold && $rose(i_cal_request);
    endsequence

    sequence s_config_write;
        ext && wr_cfg;
    endsequence

    AST_SLEEP_TRISTATE: assert property (
        s_sleep_from_active |=> ##1 (!o_data_out_en && !o_i_channel_on))
        else $error("data outputs still driven after power-down");

    AST_PULLDOWN_PAIR: assert property (
        o_weak_pulldown != o_data_out_en)
        else $error("pull-down and data drive disagree");

    AST_Q_ONLY: assert property (
        (seq_active && i_q_channel_sleep) |=> (!o_q_channel_on && o_i_channel_on))
        else $error("Q sleep did not leave I running");

    AST_CAL_FINISHES: assert property (
        (seq_cal_busy && i_power_down_request) |=> (seq_cal_busy || seq_powered_down)
            ##0 !o_weak_pulldown)
        else $error("power-down cut a calibration short");

    AST_POR_HOLD: assert property (
        (seq_por_hold && i_power_down_request) |=> !seq_cal_busy [*2])
        else $error("power-on calibration started while powered down");

    AST_CAL_DROPPED: assert property (
        s_cal_req_while_asleep |=> !seq_cal_busy [*3])
        else $error("calibration request honoured in power-down");

    AST_CAL_SKIP_Q: assert property (
        $rose(seq_cal_busy) |-> (seq_cal_q == !$past(i_q_channel_sleep)))
        else $error("Q inclusion does not follow Q sleep at start");

    AST_MODE_FIXED: assert property (
        $past(strap_done) |-> $stable(extended_control_enable))
        else $error("control mode changed while running");

    AST_DDR_BIT10: assert property (
        s_config_write |=> ##1 (o_ddr_mode == !$past(rx_data[apc_pkg::CFG_SDR_BIT], 2)))
        else $error("DDR choice does not follow written bit");

    AST_PHASE_NORMAL: assert property (
        (strap_done && !ext) |=> !o_ddr_clock_phase)
        else $error("DDR phase moved in normal mode");

    AST_EDGE_PIN: assert property (
        (strap_done && !ext) |=> (o_rising_edge_out == $past(i_output_edge_pin)))
        else $error("SDR edge does not follow pin");

    AST_SHORT_DELAY: assert property (
        (ext && strap_done && seq_por_hold && !i_power_down_request)
            |=> (int'(u_seq.cnt) == POR_SHORT_CYCLES - 1))
        else $error("long delay selected in extended mode");

    AST_NO_OFFSET_NORMAL: assert property (
        (strap_done && !ext) |=> (o_offset_adjust == apc_pkg::ADJ_NONE))
        else $error("offset trim active in normal mode");

    AST_EXT_DEFAULTS: assert property (
        ($rose(strap_done) && i_extended_control_enable) |=> ##1
            (o_ddr_mode && !o_ddr_clock_phase && o_lvds_amplitude_select
             && o_offset_adjust == apc_pkg::ADJ_NONE && !o_dual_edge_enable))
        else $error("extended defaults wrong after reset");

    AST_PINS_IGNORED: assert property (
        (strap_done && ext) |=> (!o_full_scale_select && o_extended_mode))
        else $error("range pin acted in extended mode");

endmodule : apc_top

`default_nettype wire

// file: tb/apc_host_model.sv
// Host model driving the three-wire serial write port
`timescale 1ns/10ps
`default_nettype none

module apc_host_model (
    // Clock
    input wire logic i_mclk,
    // Serial pins
    output logic o_sclk,
    output logic o_sdata,
    output logic o_scs_n
);
    // Idle: clock still, select high
    initial begin
        o_sclk = 1'b0;
        o_sdata = 1'b0;
        o_scs_n = 1'b1;
    end
    // One frame MSB first; both clock phases two cycles wide
    task automatic send(input logic [31:0] frame);
        for (int b = 31; b >= 0; b--) begin
            repeat (2) @(posedge i_mclk);
            #1 o_sclk = 1'b0;
            o_scs_n = 1'b0;
            o_sdata = frame[b];
            repeat (2) @(posedge i_mclk);
            #1 o_sclk = 1'b1;
        end
        repeat (2) @(posedge i_mclk);
        #1 o_sclk = 1'b0;
        o_scs_n = 1'b1;
        // Released line must not keep the last bit
        o_sdata = ~o_sdata;
    endtask : send
endmodule : apc_host_model

`default_nettype wire

// file: tb/test_adc_power_and_control_mode.sv
// Self-checking bench for the power and control-mode block
`timescale 1ns/10ps
`default_nettype none

module test_adc_power_and_control_mode;
    logic i_mclk = 1'b0;
    logic i_rst, i_power_down_request, i_q_channel_sleep, i_cal_request;
    logic i_extended_control_enable, i_full_scale_select, i_output_edge_pin;
    logic i_output_edge_float, i_amplitude_pin, i_calibration_delay_select;
    wire i_sclk, i_sdata, i_scs_n;
    logic o_data_out_en, o_weak_pulldown, o_i_channel_on, o_q_channel_on, o_cal_busy;
    logic o_cal_q_channel, o_ddr_mode, o_ddr_clock_phase, o_rising_edge_out;
    logic o_lvds_amplitude_select, o_extended_mode, o_full_scale_select;
    logic o_dual_edge_enable, o_dual_edge_q_input, o_dual_edge_auto_phase;
    logic [apc_pkg::ADJ_W-1:0] o_range_adjust, o_offset_adjust;
    logic [apc_pkg::DATA_W-1:0] o_phase_coarse, o_phase_fine;
    int err_total = 0;
    int samples_checked = 0;

    // Short counts keep the run brief
    apc_top #(.POR_SHORT_CYCLES(8), .POR_LONG_CYCLES(16), .CAL_CYCLES(20)) i_apc_top (.*);
    apc_host_model i_apc_host_model (.i_mclk(i_mclk), .o_sclk(i_sclk), .o_sdata(i_sdata),
        .o_scs_n(i_scs_n));

    always #4 i_mclk = ~i_mclk;

    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : cyc
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic test_done;
        $display("Checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done
    // Bounded wait on the calibration flag
    task automatic wait_cal(input logic v);
        for (int n = 0; o_cal_busy !== v; n++) begin
            cyc(1);
            if (n > 200) begin
                err_total++;
                test_done();
            end
        end
    endtask : wait_cal
    task automatic por(input logic ece);
        i_rst = 1'b1;
        i_extended_control_enable = ece;
        cyc(3);
        i_rst = 1'b0;
        cyc(2);
    endtask : por
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        i_apc_host_model.send({apc_pkg::FRAME_HEADER, a, d});
        cyc(3);
    endtask : wr

    initial begin
        {i_power_down_request, i_q_channel_sleep, i_cal_request, i_full_scale_select} = 4'h8;
        {i_output_edge_pin, i_output_edge_float, i_amplitude_pin} = 3'h2;
        i_calibration_delay_select = 1'b1;
        // Normal mode, power-down high at power-on
        por(1'b0);
        cyc(40);
        chk("cal held", 0, o_cal_busy);
        chk("sleep outs", 2'h1, {o_data_out_en, o_weak_pulldown});
        i_power_down_request = 1'b0;
        cyc(12);
        chk("long dly", 0, o_cal_busy);
        wait_cal(1'b1);
        wait_cal(1'b0);
        cyc(3);
        chk("active", 3'h2, {o_extended_mode, o_data_out_en, o_weak_pulldown});
        chk("ddr phase", 2'h2, {o_ddr_mode, o_ddr_clock_phase});
        chk("offset", 0, o_offset_adjust);
        {i_output_edge_float, i_output_edge_pin, i_amplitude_pin} = 3'h1;
        {i_full_scale_select, i_calibration_delay_select} = 2'h3;
        cyc(2);
        chk("sdr", 3'h1, {o_ddr_mode, o_rising_edge_out, o_lvds_amplitude_select});
        chk("range pin", 1, o_full_scale_select);
        chk("des", 3'h5, {o_dual_edge_enable, o_dual_edge_q_input, o_dual_edge_auto_phase});
        {i_output_edge_pin, i_amplitude_pin} = 2'h2;
        cyc(2);
        chk("edge amp", 2'h2, {o_rising_edge_out, o_lvds_amplitude_select});
        // Q asleep: calibration leaves Q out; power-down waits for cal end
        i_q_channel_sleep = 1'b1;
        cyc(3);
        chk("chans", 2'h2, {o_i_channel_on, o_q_channel_on});
        i_cal_request = 1'b1;
        wait_cal(1'b1);
        chk("cal q", 0, o_cal_q_channel);
        i_power_down_request = 1'b1;
        cyc(6);
        chk("cal runs", 1, o_cal_busy);
        wait_cal(1'b0);
        cyc(3);
        chk("sleep late", 2'h1, {o_data_out_en, o_weak_pulldown});
        i_cal_request = 1'b0;
        cyc(2);
        i_cal_request = 1'b1;
        cyc(5);
        chk("cal drop", 0, o_cal_busy);
        {i_power_down_request, i_cal_request, i_q_channel_sleep} = 3'h0;
        cyc(6);
        chk("woke", 2'h2, {o_data_out_en, o_cal_busy});
        // Power-down straight from the active state
        i_power_down_request = 1'b1;
        cyc(3);
        chk("sleep act", 3'h1, {o_data_out_en, o_i_channel_on, o_weak_pulldown});
        i_power_down_request = 1'b0;
        cyc(3);
        // Host recalibrates after waking Q
        i_cal_request = 1'b1;
        wait_cal(1'b1);
        chk("cal q", 1, o_cal_q_channel);
        // Extended mode with pins set against the defaults
        por(1'b1);
        chk("defaults", 4'ha, {o_ddr_mode, o_ddr_clock_phase, o_lvds_amplitude_select,
            o_rising_edge_out});
        chk("trims", 16'h8000, {o_range_adjust, o_offset_adjust[6:0]});
        chk("des off", 4'h8, {o_extended_mode, o_dual_edge_enable, o_full_scale_select,
            o_offset_adjust[8]});
        cyc(12);
        chk("short dly", 1, o_cal_busy);
        wait_cal(1'b0);
        cyc(3);
        wr(apc_pkg::REG_CONFIG, 16'hbdff);
        chk("cfg", 4'h5, {o_ddr_mode, o_ddr_clock_phase, o_lvds_amplitude_select,
            o_rising_edge_out});
        wr(apc_pkg::REG_OFFSET, 16'h1234);
        chk("offset", 9'h024, o_offset_adjust);
        wr(apc_pkg::REG_RANGE, 16'hff80);
        chk("range", 9'h1ff, o_range_adjust);
        wr(apc_pkg::REG_DUAL_EDGE, 16'ha000);
        chk("des", 3'h6, {o_dual_edge_enable, o_dual_edge_q_input, o_dual_edge_auto_phase});
        wr(apc_pkg::REG_COARSE, 16'h00a5);
        wr(apc_pkg::REG_FINE, 16'h005a);
        chk("coarse", 16'h00a5, o_phase_coarse);
        chk("fine", 16'h005a, o_phase_fine);
        // Unmapped address and a bad header leave the settings alone
        wr(4'h4, 16'hb2ff);
        i_apc_host_model.send({12'h002, apc_pkg::REG_CONFIG, 16'hb2ff});
        cyc(3);
        chk("cfg kept", 4'h5, {o_ddr_mode, o_ddr_clock_phase, o_lvds_amplitude_select,
            o_rising_edge_out});
        test_done();
    end
endmodule : test_adc_power_and_control_mode

`default_nettype wire
